// ===== common/sra_params.svh
// constants of the serial register access port
//
// Functional notes
// RULE_01: port selected when interface select high at reset
// RULE_02: three-wire mode shares one data line
// RULE_03: four-wire mode uses a separate data out pin
// RULE_04: chip select edge also triggers elapsed counter
// RULE_05: data out may be open drain
// RULE_06: host sends everything msb first
// RULE_07: frame is direction, 15-bit address, 8-bit data
// RULE_08: direction zero writes, one reads
// RULE_09: host frames with chip select low
// RULE_10: fifteen bits after direction form the address
// RULE_11: writes commit per whole byte at D0
// RULE_12: trailing partial byte is discarded
// RULE_13: read data changes on falling clock edges
// RULE_14: reaches registers, sram and eeprom maps
// RULE_15: address pointer increments per further byte
// RULE_16: input bits sampled on rising clock edges
// RULE_17: shared line driven only during read data
`ifndef SRA_PARAMS_SVH
`define SRA_PARAMS_SVH
`define SRA_ADDR_W 15
`define SRA_DATA_W 8
`define SRA_HDR_BITS 5'h10
`define SRA_BYTE_LAST 3'h7
`define SRA_FRAME_LAST 5'h17
`define SRA_CLK_DIV 4'h8
`endif

// ===== common/sra_pkg.sv
// types of the serial register access port
package sra_pkg;
  typedef enum logic [1:0] {SRA_IDLE, SRA_SHIFT, SRA_END} sra_host_state_t;
endpackage

// ===== common/sra_link_if.sv
// serial link between host and device end
`timescale 1ns/100ps
interface sra_link_if;
  logic sclk;
  logic csN;
  logic sdioHostOut;
  logic sdioHostOe;
  logic sdioDevOut;
  logic sdioDevOe;
  logic sdoDevOut;
  logic sdoDevOe;
  logic sdio;
  logic serial_data_out;
  // shared line: pulled up when nobody drives
  assign sdio = sdioHostOe ? sdioHostOut : (sdioDevOe ? sdioDevOut : 1'b1);
  assign serial_data_out = sdoDevOe ? sdoDevOut : 1'b1;
  modport dev (input sclk, input csN, input sdio, input sdioHostOe, output sdioDevOut, output sdioDevOe,
    output sdoDevOut, output sdoDevOe);
  modport host (output sclk, output csN, output sdioHostOut, output sdioHostOe, input sdio, input serial_data_out);
endinterface

// ===== rtl/sra_device.sv
// device end: serial register access slave
`include "sra_params.svh"
`timescale 1ns/100ps
module sra_device
  import sra_pkg::*;
#(
  parameter int MEM_DEPTH = 256
) (
  input wire logic sys_clk,
  input wire logic nrst,
  sra_link_if.dev link,
  input wire logic interfaceSelectPin,
  input wire logic threeWireDisable,
  input wire logic openDrain,
  output logic spiSelected,
  output logic elapsedTimeCounterTrigger,
  output logic wrStrobe,
  output logic [`SRA_ADDR_W-1:0] wrAddr,
  output logic [`SRA_DATA_W-1:0] wrData
);
  localparam int AW = $clog2(MEM_DEPTH);
  //////////////////////////////////////////////////////////////
  // three-flop input sampling; a level counts once the last two flops agree
  logic [2:0] sclkS_q, csS_q, sdiS_q;
  logic sclkF_q, csF_q, sdiF_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclkS_q <= 3'h0;
      sclkF_q <= 1'b0;
    end else begin
      sclkS_q <= {sclkS_q[1:0], link.sclk};
      if (sclkS_q[1] == sclkS_q[2]) begin
        sclkF_q <= sclkS_q[2];
      end
    end
  end
  // chip select idles high, so reset high to avoid a false frame start
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      csS_q <= 3'h7;
      csF_q <= 1'b1;
    end else begin
      csS_q <= {csS_q[1:0], link.csN};
      if (csS_q[1] == csS_q[2]) begin
        csF_q <= csS_q[2];
      end
    end
  end
  // data line idles at its pull-up level
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sdiS_q <= 3'h7;
      sdiF_q <= 1'b1;
    end else begin
      sdiS_q <= {sdiS_q[1:0], link.sdio};
      if (sdiS_q[1] == sdiS_q[2]) begin
        sdiF_q <= sdiS_q[2];
      end
    end
  end
  logic sclkRise, sclkFall, csFall;
  assign sclkRise = (sclkS_q[1] == sclkS_q[2]) && sclkS_q[2] && !sclkF_q;
  assign sclkFall = (sclkS_q[1] == sclkS_q[2]) && !sclkS_q[2] && sclkF_q;
  assign csFall = (csS_q[1] == csS_q[2]) && !csS_q[2] && csF_q;
  //////////////////////////////////////////////////////////////
  // RULE_01 strap caught after reset
  logic strapDone_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strapDone_q <= 1'b0;
      spiSelected <= 1'b0;
    end else if (!strapDone_q) begin
      strapDone_q <= 1'b1;
      spiSelected <= interfaceSelectPin;
    end
  end
  // RULE_04 chip select trigger
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      elapsedTimeCounterTrigger <= 1'b0;
    end else begin
      elapsedTimeCounterTrigger <= spiSelected && csFall;
    end
  end
  //////////////////////////////////////////////////////////////
  // frame shifter
  logic [4:0] hdrCnt_q;
  logic [2:0] bitCnt_q;
  logic isRead_q, dataPhase_q;
  logic [`SRA_ADDR_W-1:0] addr_q;
  logic [`SRA_DATA_W-1:0] shIn_q, shOut_q;
  logic [`SRA_DATA_W-1:0] mem [MEM_DEPTH];
  logic active, hdrRise, dataRise, byteDone;
  assign active = spiSelected && !csF_q;
  // RULE_16 bits taken on rising clock edges
  assign hdrRise = active && sclkRise && !dataPhase_q;
  assign dataRise = active && sclkRise && dataPhase_q;
  assign byteDone = dataRise && (bitCnt_q == `SRA_BYTE_LAST);
  // RULE_07 header length, then data phase
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hdrCnt_q <= 5'h0;
      dataPhase_q <= 1'b0;
    end else if (!active) begin
      hdrCnt_q <= 5'h0;
      dataPhase_q <= 1'b0;
    end else if (hdrRise) begin
      hdrCnt_q <= hdrCnt_q + 5'h1;
      if (hdrCnt_q == `SRA_HDR_BITS - 5'h1) begin
        dataPhase_q <= 1'b1;
      end
    end
  end
  // RULE_08 direction bit first
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      isRead_q <= 1'b0;
    end else if (hdrRise && (hdrCnt_q == 5'h0)) begin
      isRead_q <= sdiF_q;
    end
  end
  // RULE_10 RULE_15 address msb first, then steps per byte
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= '0;
    end else if (hdrRise && (hdrCnt_q != 5'h0)) begin
      addr_q <= {addr_q[`SRA_ADDR_W-2:0], sdiF_q};
    end else if (byteDone) begin
      addr_q <= addr_q + `SRA_ADDR_W'(1);
    end
  end
  // RULE_12 count restarts per frame, so a partial byte never commits
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_q <= 3'h0;
      shIn_q <= '0;
    end else if (!active) begin
      bitCnt_q <= 3'h0;
    end else if (dataRise) begin
      shIn_q <= {shIn_q[`SRA_DATA_W-2:0], sdiF_q};
      bitCnt_q <= bitCnt_q + 3'h1;
    end
  end
  // RULE_11 commit on D0
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wrStrobe <= 1'b0;
      wrAddr <= '0;
      wrData <= '0;
    end else begin
      wrStrobe <= byteDone && !isRead_q;
      if (byteDone && !isRead_q) begin
        wrAddr <= addr_q;
        wrData <= {shIn_q[`SRA_DATA_W-2:0], sdiF_q};
      end
    end
  end
  // RULE_14 one flat map holds registers, sram and eeprom images
  always_ff @(posedge sys_clk) begin
    if (wrStrobe) begin
      mem[wrAddr[AW-1:0]] <= wrData;
    end
  end
  //////////////////////////////////////////////////////////////
  // RULE_13 read data changes on falling edge
  logic outEn_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shOut_q <= 8'hFF;
      outEn_q <= 1'b0;
    end else if (!active) begin
      // RULE_17 release at chip select high
      outEn_q <= 1'b0;
    end else if (sclkFall && dataPhase_q && isRead_q) begin
      outEn_q <= 1'b1;
      if (bitCnt_q == 3'h0) begin
        shOut_q <= mem[addr_q[AW-1:0]];
      end else begin
        shOut_q <= {shOut_q[`SRA_DATA_W-2:0], 1'b1};
      end
    end
  end
  // RULE_02 shared line, yields while the host drives
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      link.sdioDevOut <= 1'b1;
      link.sdioDevOe <= 1'b0;
    end else begin
      link.sdioDevOut <= shOut_q[`SRA_DATA_W-1];
      link.sdioDevOe <= outEn_q && !threeWireDisable && !link.sdioHostOe;
    end
  end
  // RULE_03 RULE_05 separate data out, open drain drives zeros only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      link.sdoDevOut <= 1'b1;
      link.sdoDevOe <= 1'b0;
    end else begin
      link.sdoDevOut <= shOut_q[`SRA_DATA_W-1];
      link.sdoDevOe <= outEn_q && threeWireDisable && !(openDrain && shOut_q[`SRA_DATA_W-1]);
    end
  end
endmodule // sra_device

// ===== rtl/sra_host.sv
// host end: serial register access master
`include "sra_params.svh"
`timescale 1ns/100ps
module sra_host
  import sra_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  sra_link_if.host link,
  input wire logic reqValid,
  input wire logic reqRead,
  input wire logic [`SRA_ADDR_W-1:0] reqAddr,
  input wire logic [`SRA_DATA_W-1:0] reqData,
  input wire logic fourWire,
  output logic reqReady,
  output logic rspValid,
  output logic [`SRA_DATA_W-1:0] rspData
);
  sra_host_state_t state_q;
  logic [3:0] div_q;
  logic [23:0] sh_q;
  logic [4:0] bitCnt_q;
  logic [7:0] rd_q;
  logic [2:0] sdiS_q;
  logic rdFrame_q;
  logic tick;
  assign tick = (div_q == `SRA_CLK_DIV - 4'h1);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sdiS_q <= 3'h0;
    end else begin
      sdiS_q <= {sdiS_q[1:0], fourWire ? link.serial_data_out : link.sdio};
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 4'h0;
    end else begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SRA_IDLE;
      link.sclk <= 1'b0;
      link.csN <= 1'b1;
      link.sdioHostOut <= 1'b0;
      link.sdioHostOe <= 1'b0;
      reqReady <= 1'b1;
      rspValid <= 1'b0;
      rspData <= '0;
      sh_q <= '0;
      bitCnt_q <= 5'h0;
      rd_q <= '0;
      rdFrame_q <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      case (state_q)
        SRA_IDLE: begin
          if (reqValid && reqReady) begin
            // RULE_06 RULE_07 RULE_08 frame msb first
            sh_q <= {reqRead, reqAddr, reqData};
            rdFrame_q <= reqRead;
            link.sdioHostOut <= reqRead;
            reqReady <= 1'b0;
            // RULE_09 open frame
            link.csN <= 1'b0;
            bitCnt_q <= 5'h0;
            state_q <= SRA_SHIFT;
          end
        end
        SRA_SHIFT: begin
          if (tick) begin
            if (!link.sclk && !link.sdioHostOe && (bitCnt_q == 5'h0)) begin
              // first bit gets half a period of setup before the first rise
              link.sdioHostOe <= 1'b1;
            end else if (!link.sclk) begin
              link.sclk <= 1'b1;
            end else begin
              link.sclk <= 1'b0;
              // RULE_06 next bit set up on the fall; reads free the line after the header
              link.sdioHostOut <= sh_q[22];
              link.sdioHostOe <= !(rdFrame_q && (bitCnt_q >= `SRA_HDR_BITS - 5'h1));
              sh_q <= {sh_q[22:0], 1'b0};
              rd_q <= {rd_q[6:0], sdiS_q[2]};
              bitCnt_q <= bitCnt_q + 5'h1;
              if (bitCnt_q == `SRA_FRAME_LAST) begin
                state_q <= SRA_END;
              end
            end
          end
        end
        SRA_END: begin
          if (tick) begin
            link.csN <= 1'b1;
            link.sdioHostOe <= 1'b0;
            rspData <= rd_q;
            rspValid <= 1'b1;
            reqReady <= 1'b1;
            state_q <= SRA_IDLE;
          end
        end
        default: state_q <= SRA_IDLE;
      endcase
    end
  end
endmodule // sra_host

// ===== verification/sra_link_sva.sv
// link checker watching the wire between host and device ends
`timescale 1ns/100ps
module sra_link_sva (
  input logic sys_clk,
  input logic nrst,
  input logic sclk,
  input logic csN,
  input logic sdioHostOe,
  input logic sdioDevOut,
  input logic sdioDevOe,
  input logic sdoDevOut,
  input logic sdoDevOe,
  input logic sdio
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  // frame tracking: sclk is slow, so each rise is seen once
  logic sclk_q;
  logic dir_q;
  logic [4:0] bitCnt_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      dir_q <= 1'b0;
      bitCnt_q <= 5'h0;
    end else begin
      sclk_q <= sclk;
      if (csN) bitCnt_q <= 5'h0;
      else if (sclk && !sclk_q) bitCnt_q <= bitCnt_q + 5'h1;
      if (!csN && sclk && !sclk_q && bitCnt_q == 5'h0) dir_q <= sdio;
    end
  end
  ////////////////////////////////////////////////////////////
  a_oe_no_clash: assert property (!(sdioHostOe && sdioDevOe))
    else $error("host and device drive the shared line together");
  a_one_data_out: assert property (!(sdioDevOe && sdoDevOe))
    else $error("device drives both data outputs");
  a_sclk_idle_low: assert property (csN && $past(csN) |-> !sclk)
    else $error("serial clock moves outside a frame");
  a_frame_24_bits: assert property ($rose(csN) |-> bitCnt_q == 5'h18)
    else $error("frame length is not 24 clocks");
  a_drive_in_read: assert property ($rose(sdioDevOe || sdoDevOe) |-> !csN && dir_q && bitCnt_q >= 5'h10)
    else $error("device drives outside a read data phase");
  a_release_on_end: assert property ($rose(csN) |-> ##[0:8] (!sdioDevOe && !sdoDevOe))
    else $error("device keeps driving after frame end");
  a_sdio_fall_change: assert property (sdioDevOe && $past(sdioDevOe) && $changed(sdioDevOut) |-> !sclk)
    else $error("read bit changes while clock high");
  a_sdo_fall_change: assert property (sdoDevOe && $past(sdoDevOe) && $changed(sdoDevOut) |-> !sclk)
    else $error("data out bit changes while clock high");
  a_host_quiet_read: assert property (!csN && dir_q && bitCnt_q >= 5'h11 |-> !sdioHostOe)
    else $error("host drives during read data");
  c_write_frame: cover property ($rose(csN) && !dir_q);
  c_read_3wire: cover property ($rose(sdioDevOe));
  c_read_4wire: cover property ($rose(sdoDevOe));
endmodule // sra_link_sva

// ===== verification/tb.sv
// self-checking bench joining host and device ends
`include "sra_params.svh"
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic selPin = 1'b1;
  logic threeWireDisable = 1'b0;
  logic openDrain = 1'b0;
  logic fourWire = 1'b0;
  logic reqValid = 1'b0;
  logic reqRead = 1'b0;
  logic [`SRA_ADDR_W-1:0] reqAddr = '0;
  logic [`SRA_DATA_W-1:0] reqData = '0;
  logic reqReady, rspValid, spiSelected, trig, wrStrobe;
  logic [`SRA_DATA_W-1:0] rspData, wrData, lastData;
  logic [`SRA_ADDR_W-1:0] wrAddr, lastAddr;
  int n_mismatch = 0;
  int compares = 0;
  int nWr = 0;
  int nTrig = 0;
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////
  sra_link_if sra_link_if_i ();
  sra_host sra_host_i (.sys_clk(sys_clk), .nrst(nrst), .link(sra_link_if_i.host), .reqValid(reqValid),
    .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData), .fourWire(fourWire), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData));
  sra_device sra_device_i (.sys_clk(sys_clk), .nrst(nrst), .link(sra_link_if_i.dev), .interfaceSelectPin(selPin),
    .threeWireDisable(threeWireDisable), .openDrain(openDrain), .spiSelected(spiSelected),
    .elapsedTimeCounterTrigger(trig), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData));
  sra_link_sva sra_link_sva_i (.sys_clk(sys_clk), .nrst(nrst), .sclk(sra_link_if_i.sclk), .csN(sra_link_if_i.csN),
    .sdioHostOe(sra_link_if_i.sdioHostOe), .sdioDevOut(sra_link_if_i.sdioDevOut),
    .sdioDevOe(sra_link_if_i.sdioDevOe), .sdoDevOut(sra_link_if_i.sdoDevOut),
    .sdoDevOe(sra_link_if_i.sdoDevOe), .sdio(sra_link_if_i.sdio));
  ////////////////////////////////////////////////////////////
  // commit and trigger monitor; strobes stand one cycle only
  always @(posedge sys_clk) begin
    if (wrStrobe === 1'b1) begin
      nWr++;
      lastAddr = wrAddr;
      lastData = wrData;
    end
    if (trig === 1'b1) nTrig++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("Mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic sel);
    nrst <= 1'b0;
    selPin <= sel;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  // one whole frame; request held until taken, answer read at its edge
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    reqValid <= 1'b1;
    reqRead <= rd;
    reqAddr <= a;
    reqData <= d;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (reqReady !== 1'b1 && n < 1000);
    reqValid <= 1'b0;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (rspValid !== 1'b1 && n < 2000);
    chk({15'h0, rspValid}, 16'h0001);
    q = rspData;
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d, input int expN);
    logic [7:0] q;
    int w;
    int n;
    w = nWr;
    xfer(1'b0, a, d, q);
    n = 0;
    while (nWr == w && n < 30) begin @(posedge sys_clk); n++; end
    chk(16'(nWr - w), 16'(expN));
    if (expN > 0) chk({1'b0, lastAddr}, {1'b0, a});
    if (expN > 0) chk({8'h0, lastData}, {8'h0, d});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] q;
    logic [14:0] a;
    int t;
    do_reset(1'b1);
    chk({15'h0, spiSelected}, 16'h0001);
    // modes: three-wire, four-wire, each with openDrain low and high (three-wire ignores openDrain)
    for (int m = 0; m < 4; m++) begin
      threeWireDisable <= m[0];
      fourWire <= m[0];
      openDrain <= m[1];
      @(posedge sys_clk);
      t = nTrig;
      a = 15'h7fff - 15'(m);
      wr(a, 8'ha5 ^ 8'(m), 1);
      wr(15'(m), 8'h3c + 8'(m), 1);
      xfer(1'b1, a, 8'h00, q);
      chk({8'h0, q}, {8'h0, 8'ha5 ^ 8'(m)});
      xfer(1'b1, 15'(m), 8'h00, q);
      chk({8'h0, q}, {8'h0, 8'h3c + 8'(m)});
      chk(16'(nTrig - t), 16'h0004);
    end
    // port not chosen at reset: link ignored, lines float to pull-up
    do_reset(1'b0);
    chk({15'h0, spiSelected}, 16'h0000);
    wr(15'h0010, 8'h00, 0);
    xfer(1'b1, 15'h7fff, 8'h00, q);
    chk({8'h0, q}, 16'h00ff);
    final_report();
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule // tb
